// >>> hdl/fmp_ctl_end.sv
// Purpose: video controller end driving both memory ports
// Assumes: user restarts only while o_restart_ready is high
// Notes:   serial clocks are divided enables; write data passes a fifo

`timescale 1ns/1ns

module fmp_ctl_end import fmp_pkg::*; (
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  fmp_link_if.ctl                link,
  input  wire logic              i_wr_valid,
  input  wire logic [WORD_W-1:0] i_wr_data,
  input  wire logic              i_wr_keep,
  output logic                   o_wr_ready,
  input  wire logic              i_restart,
  input  wire logic              i_blk_en,
  input  wire logic [BLK_W-1:0]  i_blk_addr,
  output logic                   o_restart_ready,
  input  wire logic              i_rd_take,
  output logic      [WORD_W-1:0] o_rd_data,
  output logic                   o_rd_valid
);

  typedef struct packed {
    logic [1:0]        div;
    logic              wclk;
    logic              rclk;
    logic              wrst;
    logic              we;
    logic              ie;
    logic [WORD_W-1:0] dbus;
    logic [WORD_W-1:0] hold;
    logic              rrst;
    logic              re;
    logic              oe;
    logic [CNT_W-1:0]  seq;
    logic              blk_mode;
    logic [BLK_W-1:0]  blk;
    logic [4:0]        adv;
    logic              pend;
    logic              pend_blk;
    logic [BLK_W-1:0]  pend_addr;
    logic              re_seen;
    logic              ready;
    logic [WORD_W-1:0] rd_data;
    logic              rd_valid;
  } fmp_ctl_st_t;

  fmp_ctl_st_t      st_ff;
  fmp_ctl_st_t      nxt_st;
  logic             tick;
  logic             f_valid;
  logic [FIFO_W-1:0] f_data;

  assign tick = (st_ff.div == CLK_DIV_LAST);

  fmp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (i_wr_valid),
    .i_in_data   ({i_wr_keep, i_wr_data}),
    .o_in_ready  (o_wr_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (tick)
  );

  assign link.serial_write_clock  = st_ff.wclk;
  assign link.serial_read_clock   = st_ff.rclk;
  assign link.write_pointer_reset = st_ff.wrst;
  assign link.store_advance       = st_ff.we;
  assign link.input_mask_enable   = st_ff.ie;
  assign link.input_bus           = st_ff.dbus;
  assign link.read_pointer_reset  = st_ff.rrst;
  assign link.fetch_advance       = st_ff.re;
  assign link.drive_enable        = st_ff.oe;
  assign o_restart_ready = st_ff.ready;
  assign o_rd_data       = st_ff.rd_data;
  assign o_rd_valid      = st_ff.rd_valid;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.div      = st_ff.div + 2'h1;
    nxt_st.wclk     = tick;
    nxt_st.rclk     = tick;
    nxt_st.rd_valid = 1'b0;
    if (i_restart) begin
      nxt_st.pend      = 1'b1;
      nxt_st.pend_blk  = i_blk_en;
      nxt_st.pend_addr = i_blk_addr;
    end
    if (tick) begin
      // -----------------------------------------------------------
      // write side: advance one tick ahead of its data
      // -----------------------------------------------------------
      nxt_st.wrst = 1'b0;
      nxt_st.we   = f_valid;
      nxt_st.ie   = f_valid & f_data[WORD_W];
      nxt_st.dbus = st_ff.hold;
      if (f_valid) begin
        nxt_st.hold = f_data[WORD_W-1:0];
      end

      // -----------------------------------------------------------
      // read side
      // -----------------------------------------------------------
      nxt_st.rrst    = 1'b0;
      nxt_st.re_seen = 1'b0;
      if (st_ff.re_seen && link.out_drive) begin
        nxt_st.rd_data  = link.output_bus;
        nxt_st.rd_valid = 1'b1;
      end
      if (st_ff.pend && st_ff.seq == '0 && st_ff.adv == ADV_MIN) begin
        nxt_st.pend     = i_restart;
        nxt_st.wrst     = 1'b1;
        nxt_st.rrst     = 1'b1;
        nxt_st.re       = 1'b0;
        nxt_st.oe       = 1'b0;
        nxt_st.seq      = ENT_FIRST;
        nxt_st.adv      = '0;
        nxt_st.blk_mode = st_ff.pend_blk;
        nxt_st.blk      = st_ff.pend_addr;
      end else if (st_ff.seq == '0) begin
        nxt_st.re      = i_rd_take;
        nxt_st.oe      = 1'b1;
        nxt_st.re_seen = i_rd_take;
        if (i_rd_take && st_ff.adv != ADV_MIN) begin
          nxt_st.adv = st_ff.adv + 5'h01;
        end
      end else begin
        nxt_st.seq = st_ff.seq + 6'h01;
        if (st_ff.seq <= ENT_PAIR) begin
          nxt_st.re = 1'b1;
          nxt_st.oe = ~st_ff.blk_mode;
          if (!st_ff.blk_mode) begin
            nxt_st.seq = '0;
          end
        end else if (st_ff.seq <= ENT_LAST) begin
          nxt_st.re = 1'b0;
          nxt_st.oe = 1'b1;
        end else if (st_ff.seq <= ADDR_LAST) begin
          nxt_st.re  = 1'b0;
          nxt_st.oe  = st_ff.blk[BLK_W-1];
          nxt_st.blk = {st_ff.blk[BLK_W-2:0], 1'b0};
        end else begin
          nxt_st.re = 1'b0;
          nxt_st.oe = 1'b0;
          if (st_ff.seq == SEQ_END) begin
            nxt_st.seq = '0;
          end
        end
      end
    end
    nxt_st.ready = ~nxt_st.pend & (nxt_st.seq == '0)
                 & (nxt_st.adv == ADV_MIN);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '{adv: ADV_MIN, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : fmp_ctl_end

// >>> hdl/fmp_pkg.sv
// Purpose: shared constants and types for the field memory pointer ports
// Assumes: one system clock; serial clocks are one-cycle enable pulses
// Notes:   pointer index 0..11 is the mini cache, 12.. is the main array

package fmp_pkg;

  // ---------------------------------------------------------------
  // data and address layout
  // ---------------------------------------------------------------
  localparam int             WORD_W       = 12;
  localparam int             PTR_W        = 18;
  localparam int             BLK_W        = 13;
  localparam int             TOTAL_WORDS  = 245772;
  localparam logic [17:0]    CACHE_WORDS  = 18'h0000c;
  localparam logic [17:0]    LAST_INDEX   = 18'h3c00b;
  localparam logic [17:0]    BLOCK_WORDS  = 18'h00028;
  localparam logic [12:0]    BLOCK_MAX    = 13'h17ff;

  // ---------------------------------------------------------------
  // read block entry sequence, counted in read clock edges
  // ---------------------------------------------------------------
  localparam int             CNT_W        = 6;
  localparam logic [5:0]     ENT_FIRST    = 6'h01;
  localparam logic [5:0]     ENT_PAIR     = 6'h02;
  localparam logic [5:0]     HIZ_FIRST    = 6'h03;
  localparam logic [5:0]     ENT_LAST     = 6'h04;
  localparam logic [5:0]     ADDR_LAST    = 6'h11;
  localparam logic [5:0]     LAT_LAST     = 6'h14;
  localparam logic [5:0]     SEQ_END      = 6'h25;

  // ---------------------------------------------------------------
  // controller timing
  // ---------------------------------------------------------------
  localparam logic [1:0]     CLK_DIV_LAST = 2'h3;
  localparam logic [4:0]     ADV_MIN      = 5'h14;
  localparam int             FIFO_DEPTH   = 16;
  localparam int             FIFO_W       = 13;

  typedef enum logic [2:0] {
    RS_NORM = 3'b000,
    RS_ENT  = 3'b001,
    RS_ADDR = 3'b010,
    RS_LAT  = 3'b011,
    RS_LOCK = 3'b100
  } fmp_rd_state_t;

endpackage : fmp_pkg

// >>> hdl/fmp_link_if.sv
// Purpose: link between the field memory and its video controller
// Assumes: serial clocks are enable pulses of the common clock
// Notes:   output bus level is resolved here from the drive flag

`timescale 1ns/1ns

interface fmp_link_if import fmp_pkg::*; ();
  logic              serial_write_clock;
  logic              write_pointer_reset;
  logic              store_advance;
  logic              input_mask_enable;
  logic [WORD_W-1:0] input_bus;
  logic              serial_read_clock;
  logic              read_pointer_reset;
  logic              fetch_advance;
  logic              drive_enable;
  logic [WORD_W-1:0] out_data;
  logic              out_drive;
  wire  [WORD_W-1:0] output_bus;

  assign output_bus = out_drive ? out_data : '0;

  modport dev (
    input  serial_write_clock, write_pointer_reset, store_advance,
    input  input_mask_enable, input_bus,
    input  serial_read_clock, read_pointer_reset, fetch_advance,
    input  drive_enable,
    output out_data, out_drive
  );

  modport ctl (
    output serial_write_clock, write_pointer_reset, store_advance,
    output input_mask_enable, input_bus,
    output serial_read_clock, read_pointer_reset, fetch_advance,
    output drive_enable,
    input  output_bus, out_drive
  );
endinterface : fmp_link_if

// >>> hdl/fmp_fifo.sv
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: depth is a power of two
// Notes:   full and empty are registered flags

`timescale 1ns/1ns

module fmp_fifo import fmp_pkg::*; #(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          full;
    logic          empty;
  } fmp_fifo_st_t;

  fmp_fifo_st_t     st_ff;
  fmp_fifo_st_t     nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic             push;
  logic             pop;

  assign o_in_ready  = ~st_ff.full;
  assign o_out_valid = ~st_ff.empty;
  assign o_out_data  = mem_ff[st_ff.rd];
  assign push        = i_in_valid & ~st_ff.full;
  assign pop         = i_out_ready & ~st_ff.empty;

  // ---------------------------------------------------------------
  // pointers and flags
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr = st_ff.wr + AW'(1);
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + AW'(1);
    end
    nxt_st.cnt   = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    nxt_st.full  = (nxt_st.cnt == (AW+1)'(DEPTH));
    nxt_st.empty = (nxt_st.cnt == '0);
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '{wr: '0, rd: '0, cnt: '0, full: 1'b0, empty: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_ff[st_ff.wr] <= i_in_data;
    end
  end
endmodule : fmp_fifo

// >>> hdl/fmp_mem_end.sv
// Purpose: field memory end: write port, read port, block read entry
// Assumes: serial clocks arrive as one-cycle enable pulses
// Notes:   index 0..11 is the mini cache, index 12.. is array word 0..

`timescale 1ns/1ns

module fmp_mem_end import fmp_pkg::*; (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  fmp_link_if.dev   link,
  output logic      o_block_busy,
  output logic      o_read_locked
);

  typedef struct packed {
    logic              wrst_q;
    logic              wrst_pend;
    logic              we_q;
    logic              ie_q;
    logic [PTR_W-1:0]  waddr;
    logic [PTR_W-1:0]  wptr;
    logic              rrst_q;
    logic              rrst_pend;
    fmp_rd_state_t     rs;
    logic [CNT_W-1:0]  cnt;
    logic [BLK_W-1:0]  blk;
    logic [PTR_W-1:0]  rptr;
    logic [WORD_W-1:0] q;
    logic              drv;
    logic              busy;
    logic              locked;
  } fmp_dev_st_t;

  fmp_dev_st_t       st_ff;
  fmp_dev_st_t       nxt_st;
  logic [WORD_W-1:0] mem_ff [TOTAL_WORDS];
  logic              wr_en;
  logic [PTR_W-1:0]  wr_addr;
  logic [CNT_W-1:0]  cnt_inc;
  logic              fa;
  logic              de;
  logic              hiz;
  logic [BLK_W-1:0]  blk_sh;

  // ---------------------------------------------------------------
  // pointer step with wrap past the last array word
  // ---------------------------------------------------------------
  function automatic logic [PTR_W-1:0] ptr_step(
    input logic [PTR_W-1:0] p
  );
    ptr_step = (p == LAST_INDEX) ? CACHE_WORDS : p + 18'h00001;
  endfunction : ptr_step

  assign o_block_busy  = st_ff.busy;
  assign o_read_locked = st_ff.locked;
  assign link.out_data  = st_ff.q;
  assign link.out_drive = st_ff.drv;
  assign fa      = link.fetch_advance;
  assign de      = link.drive_enable;
  assign cnt_inc = st_ff.cnt + 6'h01;
  assign blk_sh  = {st_ff.blk[BLK_W-2:0], de};

  always_comb begin
    nxt_st  = st_ff;
    wr_en   = 1'b0;
    wr_addr = st_ff.waddr;
    hiz     = 1'b0;

    // -------------------------------------------------------------
    // write port
    // -------------------------------------------------------------
    nxt_st.wrst_q = link.write_pointer_reset;
    if (link.serial_write_clock) begin
      nxt_st.wrst_pend = 1'b0;
      if (st_ff.wrst_pend) begin
        nxt_st.wptr = '0;
      end else if (link.store_advance) begin
        nxt_st.waddr = st_ff.wptr;
        nxt_st.wptr  = ptr_step(st_ff.wptr);
      end
      nxt_st.we_q = link.store_advance;
      nxt_st.ie_q = link.input_mask_enable;
      wr_en = st_ff.we_q & st_ff.ie_q;
    end
    if (link.write_pointer_reset && !st_ff.wrst_q) begin
      nxt_st.wrst_pend = 1'b1;
    end

    // -------------------------------------------------------------
    // read port
    // -------------------------------------------------------------
    nxt_st.rrst_q = link.read_pointer_reset;
    if (link.serial_read_clock) begin
      if (st_ff.rrst_pend && (fa || st_ff.rs != RS_NORM)) begin
        nxt_st.rrst_pend = 1'b0;
        nxt_st.rptr      = '0;
        nxt_st.cnt       = ENT_FIRST;
        nxt_st.rs        = (fa && !de) ? RS_ENT : RS_NORM;
      end else begin
        if (fa && (st_ff.rs == RS_NORM || st_ff.rs == RS_ENT)) begin
          nxt_st.q    = mem_ff[st_ff.rptr];
          nxt_st.rptr = ptr_step(st_ff.rptr);
        end
        case (st_ff.rs)
          RS_ENT: begin
            nxt_st.cnt = cnt_inc;
            if ((cnt_inc <= ENT_PAIR) ? !(fa && !de) : !(!fa && de)) begin
              nxt_st.rs = RS_NORM;
            end else if (cnt_inc == ENT_LAST) begin
              nxt_st.rs = RS_ADDR;
            end
          end
          RS_ADDR: begin
            nxt_st.cnt = cnt_inc;
            nxt_st.blk = blk_sh;
            if (cnt_inc == ADDR_LAST) begin
              nxt_st.cnt = '0;
              nxt_st.rs  = (blk_sh > BLOCK_MAX) ? RS_LOCK : RS_LAT;
            end
          end
          RS_LAT: begin
            nxt_st.cnt = cnt_inc;
            if (cnt_inc == LAT_LAST) begin
              nxt_st.rptr = CACHE_WORDS
                          + PTR_W'(st_ff.blk) * BLOCK_WORDS;
              nxt_st.rs   = RS_NORM;
            end
          end
          default: begin
            nxt_st.rs = st_ff.rs;
          end
        endcase
      end
      hiz = (nxt_st.rs == RS_ENT && nxt_st.cnt >= HIZ_FIRST)
          || nxt_st.rs == RS_ADDR
          || (st_ff.rs == RS_ADDR && nxt_st.rs != RS_NORM);
      nxt_st.drv = de & ~hiz;
    end
    if (link.read_pointer_reset && !st_ff.rrst_q) begin
      nxt_st.rrst_pend = 1'b1;
    end
    nxt_st.busy   = (nxt_st.rs == RS_ENT) || (nxt_st.rs == RS_ADDR)
                  || (nxt_st.rs == RS_LAT);
    nxt_st.locked = (nxt_st.rs == RS_LOCK);
  end

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '{rs: RS_NORM, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge i_clock) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= link.input_bus;
    end
  end
endmodule : fmp_mem_end

// >>> test/fmp_link_assertions.sv
// Purpose: concurrent checks on the link between the two ends
// Assumes: serial clocks are one-cycle enables of the common clock
// Notes:   instantiated beside the link in the bench, no bind
`timescale 1ns/1ns
module fmp_link_assertions import fmp_pkg::*; (
  input wire logic              i_clock,
  input wire logic              i_rst_b,
  input wire logic              serial_write_clock,
  input wire logic              write_pointer_reset,
  input wire logic              store_advance,
  input wire logic              input_mask_enable,
  input wire logic              serial_read_clock,
  input wire logic              read_pointer_reset,
  input wire logic              fetch_advance,
  input wire logic              drive_enable,
  input wire logic [WORD_W-1:0] out_data,
  input wire logic              out_drive
);
  // ------------------------------------------------------------
  // link checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  wclk_spacing_a: assert property (serial_write_clock |=>
    !serial_write_clock [*3] ##1 serial_write_clock)
    else $error("write clock pulse spacing wrong");
  rclk_spacing_a: assert property (
    serial_read_clock ##1 !serial_read_clock [*3] |=> serial_read_clock)
    else $error("read clock pulse spacing wrong");
  float_on_low_a: assert property (
    serial_read_clock && !drive_enable |=> !out_drive)
    else $error("output driven with enable low");
  drive_on_high_a: assert property (
    serial_read_clock && drive_enable && fetch_advance |=> out_drive)
    else $error("output floating with enable high");
  out_hold_a: assert property (
    !serial_read_clock |=> $stable(out_data) && $stable(out_drive))
    else $error("output changed without a read edge");
  reset_pair_a: assert property (
    $rose(read_pointer_reset) |-> write_pointer_reset)
    else $error("read reset without write reset");
  reset_gap_a: assert property (
    $fell(read_pointer_reset) |-> !read_pointer_reset [*4])
    else $error("read reset low too briefly");
  reset_start_a: assert property (
    serial_read_clock && read_pointer_reset |->
      !fetch_advance ##4 fetch_advance)
    else $error("read start without advance");

  cover property (serial_read_clock && read_pointer_reset);
  cover property (serial_write_clock && store_advance && !input_mask_enable);
  cover property (serial_read_clock && fetch_advance && !drive_enable);
  cover property ($rose(out_drive));
endmodule : fmp_link_assertions

// >>> test/field_memory_pointer_ports_tb.sv
// Purpose: end-to-end bench joining both ends through the link
// Assumes: the controller user side makes every memory access
// Notes:   random data from a fixed seed plus corner words
`timescale 1ns/1ns
module field_memory_pointer_ports_tb import fmp_pkg::*; ();
  // ------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------
  logic              clock = 1'h0;
  logic              rst_b = 1'h0;
  logic              wr_valid = 1'h0;
  logic [WORD_W-1:0] wr_data = 12'h000;
  logic              wr_keep = 1'h0;
  logic              restart = 1'h0;
  logic              blk_en = 1'h0;
  logic [BLK_W-1:0]  blk_addr = 13'h0000;
  logic              rd_take = 1'h0;
  logic              wr_ready;
  logic              rs_ready;
  logic              rd_valid;
  logic              blk_busy;
  logic              rd_locked;
  logic [WORD_W-1:0] rd_data;
  logic [WORD_W-1:0] wa [96];
  logic [WORD_W-1:0] wb [30];
  logic              kb [30];
  logic [WORD_W-1:0] got [$];
  logic [BLK_W-1:0]  blks [3] = '{13'h0001, 13'h0000, 13'h17ff};
  integer            seed = 32'h665e0d60;
  int                miscompares = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                n_full = 0;
  int                n_float = 0;
  int                n_busy = 0;

  fmp_link_if link ();

  fmp_mem_end u_fmp_mem_end (
    .i_clock      (clock),
    .i_rst_b      (rst_b),
    .link         (link.dev),
    .o_block_busy (blk_busy),
    .o_read_locked(rd_locked)
  );

  fmp_ctl_end u_fmp_ctl_end (
    .i_clock        (clock),
    .i_rst_b        (rst_b),
    .link           (link.ctl),
    .i_wr_valid     (wr_valid),
    .i_wr_data      (wr_data),
    .i_wr_keep      (wr_keep),
    .o_wr_ready     (wr_ready),
    .i_restart      (restart),
    .i_blk_en       (blk_en),
    .i_blk_addr     (blk_addr),
    .o_restart_ready(rs_ready),
    .i_rd_take      (rd_take),
    .o_rd_data      (rd_data),
    .o_rd_valid     (rd_valid)
  );

  fmp_link_assertions u_fmp_link_assertions (
    .i_clock            (clock),
    .i_rst_b            (rst_b),
    .serial_write_clock (link.serial_write_clock),
    .write_pointer_reset(link.write_pointer_reset),
    .store_advance      (link.store_advance),
    .input_mask_enable  (link.input_mask_enable),
    .serial_read_clock  (link.serial_read_clock),
    .read_pointer_reset (link.read_pointer_reset),
    .fetch_advance      (link.fetch_advance),
    .drive_enable       (link.drive_enable),
    .out_data           (link.out_data),
    .out_drive          (link.out_drive)
  );

  always #5 clock = ~clock;

  // watch busy, float and fifo refusal; cut a hang short
  always @(negedge clock) begin
    cycles++;
    if (rst_b && wr_ready === 1'h0) n_full++;
    if (blk_busy === 1'h1) n_busy++;
    if (blk_busy === 1'h1 && link.out_drive !== 1'h0) n_float++;
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic do_restart(input logic en, input logic [BLK_W-1:0] addr);
    int t;
    t = 0;
    while (rs_ready !== 1'h1 && t < 2000) begin
      @(negedge clock);
      t++;
    end
    chk(rs_ready, 1'h1);
    n_busy = 0;
    restart = 1'h1;
    blk_en = en;
    blk_addr = addr;
    @(negedge clock);
    restart = 1'h0;
    // let the word of the last advance of the previous read go by
    repeat (8) @(negedge clock);
  endtask : do_restart

  // ready is a registered flag, so its value here holds to the next edge
  task automatic push(input int n, input logic ph);
    int   i;
    logic ok;
    i = 0;
    while (i < n) begin
      wr_valid = 1'h1;
      wr_data = ph ? wb[i] : wa[i];
      wr_keep = ph ? kb[i] : 1'h1;
      ok = wr_ready;
      @(negedge clock);
      if (ok === 1'h1) i++;
    end
    wr_valid = 1'h0;
    repeat (100) @(negedge clock);
  endtask : push

  task automatic take(input int n);
    int t;
    got.delete();
    t = 0;
    rd_take = 1'h1;
    while (got.size() < n && t < 3000) begin
      @(negedge clock);
      t++;
      if (rd_valid === 1'h1) got.push_back(rd_data);
    end
    rd_take = 1'h0;
    chk(16'(got.size()), 16'(n));
  endtask : take

  // array word 40n+k sits behind the 12 cache words of the stream
  function automatic logic [WORD_W-1:0] blk_word(input int b, input int k);
    return wa[12 + (40 * b + k) % 245760];
  endfunction : blk_word

  function automatic logic [WORD_W-1:0] masked(input int i);
    return kb[i] ? wb[i] : wa[i];
  endfunction : masked

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 96; i++) wa[i] = 12'($random(seed));
    for (int i = 0; i < 30; i++) begin
      wb[i] = 12'($random(seed));
      kb[i] = 1'($random(seed));
    end
    wa[0] = 12'hfff;
    wa[1] = 12'h000;
    kb[0] = 1'h0;
    kb[29] = 1'h0;
    repeat (3) @(negedge clock);
    rst_b = 1'h1;
    do_restart(1'h0, 13'h0000);
    take(20);
    push(96, 1'h0);
    do_restart(1'h0, 13'h0000);
    take(96);
    for (int i = 0; i < 96; i++) chk(got[i], wa[i]);
    chk(n_full > 0, 1'h1);
    for (int j = 0; j < 3; j++) begin
      do_restart(1'h1, blks[j]);
      take(j == 2 ? 41 : 20);
      chk(16'(n_busy), 16'h0090);
      for (int k = 0; k < got.size(); k++)
        if (j < 2 || k == 40) chk(got[k], blk_word(int'(blks[j]), k));
    end
    chk(16'(n_float), 16'h0000);
    do_restart(1'h1, 13'h1800);
    rd_take = 1'h1;
    repeat (300) @(negedge clock);
    rd_take = 1'h0;
    chk(rd_locked, 1'h1);
    do_restart(1'h0, 13'h0000);
    take(20);
    chk(rd_locked, 1'h0);
    for (int i = 0; i < 20; i++) chk(got[i], wa[i]);
    push(30, 1'h1);
    do_restart(1'h0, 13'h0000);
    take(30);
    for (int i = 0; i < 30; i++) chk(got[i], masked(i));
    conclude();
  end
endmodule : field_memory_pointer_ports_tb
